// *** rtl/config_pin_reuse_mux.sv ***
// Configuration pin role selection between edit mode and user mode
`timescale 1ns/1ps
module config_pin_reuse_mux (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Configuration engine status
    input wire logic config_ok,            // Configuration succeeded
    input wire logic config_fail,          // Configuration failed
    input wire logic edit_reenter,         // Request to re-enter edit mode
    input wire logic manual_scan_cfg,      // Configuration came over scan port
    // Options and straps
    input wire pin_reuse_pkg::reuse_opt_s reuse_opt,
    input wire logic [2:0] mode_pins,
    input wire logic select_bonded,        // Scan port select pin is bonded
    input wire logic small_family,         // Family allowing combined release
    // Configuration pins sampled
    input wire logic scan_port_select_n,
    input wire logic reload_request_n,
    input wire logic ready_in,
    // Results
    output pin_reuse_pkg::pin_role_s pin_role,
    output logic user_mode,
    output logic done_out,
    output logic reload_start
);
    import pin_reuse_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    cfg_state_e state_r, state_nxt;      // Sequencer state
    pin_role_s role_r, role_nxt;         // Registered pin roles
    logic [3:0] low_cnt_r;               // Reload low length counter
    logic reload_fire;                   // Valid reload pulse seen
    logic reload_start_r;                // Reload pulse output register
    logic done_r;                        // Done output register
    logic user_mode_r;                   // User mode output register
    logic scan_latch_r, scan_latch_nxt;  // Combined scan release latch
    logic scan_manual_r;                 // Entered user mode by manual scan cfg
    logic hold;                          // Reload or ready pulled low
    logic shared_mode;                   // Serial-stream or parallel-bus mode
    logic combined_case;                 // Small family in slave serial mode

    assign hold = !reload_request_n || !ready_in;
    assign shared_mode = (mode_pins == MODE_SERIAL_STREAM) || (mode_pins == MODE_PARALLEL_BUS);
    assign combined_case = small_family && (mode_pins == MODE_SLAVE_SERIAL);

    // ****************************************************************
    // Reload request pulse measurement
    // ****************************************************************
    // Count low cycles, saturating at the least pulse length
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            low_cnt_r <= 4'h0;
        end else if (reload_request_n) begin
            low_cnt_r <= 4'h0;
        end else if (low_cnt_r != RELOAD_CNT_MAX) begin
            low_cnt_r <= low_cnt_r + 4'h1;
        end
    end

    // Fire on release after a long enough low
    assign reload_fire = reload_request_n && (low_cnt_r == RELOAD_CNT_MAX);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reload_start_r <= 1'b0;
        end else begin
            reload_start_r <= reload_fire;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Next state: user mode only after success and no hold
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_EDIT: begin
                if (config_fail) begin
                    state_nxt = ST_FAIL;
                end else if (config_ok && !hold && !reload_fire) begin
                    // A reload released on the same edge restarts instead
                    state_nxt = ST_USER;
                end
            end
            ST_USER, ST_FAIL: begin
                if (reload_fire || edit_reenter) begin
                    state_nxt = ST_EDIT;
                end
            end
            default: begin
                state_nxt = ST_EDIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_r <= ST_EDIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************************************
    // Scan release memory
    // ****************************************************************
    // Latch combined release; only edit mode clears it
    always_comb begin
        scan_latch_nxt = scan_latch_r;
        if (state_nxt != ST_USER) begin
            scan_latch_nxt = 1'b0;
        end else if (combined_case && select_bonded && reuse_opt.scan && scan_port_select_n) begin
            scan_latch_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            scan_latch_r <= 1'b0;
        end else begin
            scan_latch_r <= scan_latch_nxt;
        end
    end

    // Remember how user mode was entered when no select pin exists
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            scan_manual_r <= 1'b0;
        end else if (state_r == ST_EDIT && state_nxt == ST_USER) begin
            scan_manual_r <= manual_scan_cfg;
        end else if (state_nxt != ST_USER) begin
            scan_manual_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Pin role selection
    // ****************************************************************
    always_comb begin
        role_nxt = ROLE_RESET;
        if (state_nxt == ST_USER) begin
            if (!select_bonded) begin
                // Manual scan configuration releases the scan pins
                role_nxt.scan = (state_r == ST_EDIT) ? manual_scan_cfg : scan_manual_r;
            end else if (!reuse_opt.scan) begin
                role_nxt.select = 1'b1;
            end else begin
                // Select pin steers the scan pins; it is released with them once the combined release latches
                role_nxt.scan = scan_latch_nxt || scan_port_select_n;
                role_nxt.select = scan_latch_nxt;
            end
            role_nxt.twowire = reuse_opt.twowire;
            role_nxt.slave = reuse_opt.slave && !shared_mode;
            role_nxt.master = reuse_opt.master && !shared_mode;
            role_nxt.reload = reuse_opt.reload;
            role_nxt.ready = reuse_opt.ready;
            role_nxt.done = reuse_opt.done;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            role_r <= ROLE_RESET;
        end else begin
            role_r <= role_nxt;
        end
    end

    // Done driven high only in user mode without hold
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_nxt == ST_USER) && !hold;
        end
    end

    // User mode flag kept in its own flop, in step with the state register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            user_mode_r <= 1'b0;
        end else begin
            user_mode_r <= (state_nxt == ST_USER);
        end
    end

    assign pin_role = role_r;
    assign user_mode = user_mode_r;
    assign done_out = done_r;
    assign reload_start = reload_start_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence seq_reload_low;
        !reload_request_n [*7];
    endsequence

    sequence seq_reload_release;
        seq_reload_low ##1 reload_request_n;
    endsequence

    chk_roles_outside_user: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_r != ST_USER |-> role_r == ROLE_RESET)
        else $error("pin released outside user mode");

    chk_user_after_ok: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(user_mode) |-> $past(config_ok))
        else $error("user mode without configuration success");

    chk_scan_default: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_nxt == ST_USER && select_bonded && !reuse_opt.scan
        |=> !role_r.scan && role_r.select)
        else $error("scan default roles wrong");

    chk_scan_select_steer: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_nxt == ST_USER && select_bonded && reuse_opt.scan && !combined_case
        && !scan_latch_r |=> role_r.scan == $past(scan_port_select_n))
        else $error("scan pins not steered by select pin");

    chk_twowire_opt: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_nxt == ST_USER |=> role_r.twowire == $past(reuse_opt.twowire))
        else $error("two-wire role mismatch");

    chk_shared_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
        shared_mode |=> !role_r.slave && !role_r.master)
        else $error("shared mode pins released");

    chk_scan_latch_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        scan_latch_r && state_nxt == ST_USER |=> role_r.scan && role_r.select)
        else $error("latched scan release lost");

    chk_reload_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
        seq_reload_release |=> reload_start && !user_mode)
        else $error("long reload pulse ignored");

    chk_opt_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_nxt == ST_USER |=> role_r.reload == $past(reuse_opt.reload)
        && role_r.ready == $past(reuse_opt.ready) && role_r.done == $past(reuse_opt.done))
        else $error("reload, ready or done role mismatch");

    chk_done_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        hold |=> !done_out)
        else $error("done high while held");

endmodule

// *** rtl/pin_reuse_pkg.sv ***
// Constants, states and carriers for the configuration pin reuse multiplexer
// ****************************************************************
// ****************************************************************
package pin_reuse_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;      // 250 MHz reference clock
    localparam int RELOAD_MIN_NS = 25;        // Least reload request low time
    // Least time rounds up to whole cycles
    localparam int RELOAD_MIN_CYC = (RELOAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] RELOAD_CNT_MAX = 4'(RELOAD_MIN_CYC);

    // ****************************************************************
    // Mode pin codes
    // ****************************************************************
    localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h1;  // Slave serial port mode
    localparam logic [2:0] MODE_SERIAL_STREAM = 3'h5; // Shared serial-stream mode
    localparam logic [2:0] MODE_PARALLEL_BUS = 3'h7;  // Shared parallel-bus mode

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_EDIT = 2'b00,  // Configuring, all pins dedicated
        ST_USER = 2'b01,  // Configured, reuse options applied
        ST_FAIL = 2'b10   // Configuration failed, pins dedicated
    } cfg_state_e;

    // ****************************************************************
    // Carriers: reuse options and resulting pin roles (1 = general I/O)
    // ****************************************************************
    typedef struct packed {
        logic scan;     // Scan port option
        logic twowire;  // Two-wire port option
        logic slave;    // Slave serial port option
        logic master;   // Master flash read port option
        logic reload;   // Reload request pin option
        logic ready;    // Ready pin option
        logic done;     // Done pin option
    } reuse_opt_s;

    typedef struct packed {
        logic select;   // Scan port select pin
        logic scan;     // TMS, TCK, TDI, TDO
        logic twowire;  // SCL, SDA
        logic slave;    // Five slave serial port pins
        logic master;   // Five master flash read port pins
        logic reload;   // Reload request pin
        logic ready;    // Ready pin
        logic done;     // Done pin
    } pin_role_s;

    localparam pin_role_s ROLE_RESET = '0;  // Every pin in configuration role

endpackage

// *** tb/cfg_host_model.sv ***
// Behavioural model of the configuration host and the board straps
`timescale 1ns/1ps
module cfg_host_model (
    // Clock
    input wire logic ref_clk,
    // Pins driven toward the device
    output logic [2:0] mode_pins,
    output logic scan_port_select_n,
    output logic reload_request_n,
    output logic ready_in
);
    // Non-auto mode strapped from power-up while scan reuse is exercised
    initial begin
        mode_pins = 3'h1;
        scan_port_select_n = 1'b1;
        reload_request_n = 1'b1;
        ready_in = 1'b1;
    end
    // Straps and ready level, called just after a falling edge
    task automatic set_pins(input logic [2:0] mode, input logic sel_n, input logic rdy);
        mode_pins = mode;
        scan_port_select_n = sel_n;
        ready_in = rdy;
    endtask
    // Reload request held low over a whole number of sampling edges
    task automatic pulse_reload(input int low_cycles);
        reload_request_n = 1'b0;
        repeat (low_cycles) @(negedge ref_clk);
        reload_request_n = 1'b1;
    endtask
endmodule

// *** tb/config_pin_reuse_mux_tb.sv ***
// Self-checking bench for the configuration pin reuse multiplexer
`timescale 1ns/1ps
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module config_pin_reuse_mux_tb;
    import pin_reuse_pkg::*;
    logic ref_clk, rstn, config_ok, config_fail, edit_reenter, manual_scan_cfg;
    logic select_bonded, small_family, user_mode, done_out, reload_start;
    logic scan_port_select_n, reload_request_n, ready_in;
    logic [2:0] mode_pins;
    reuse_opt_s reuse_opt;
    pin_role_s pin_role;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // ****************************************************************
    // Clock, hang guard and helpers
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Cycle ceiling, well above the length of the sequence
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Synchronous reset over twelve edges, then one quiet edge
    task automatic reset_dut();
        rstn = 1'b0;
        step(12);
        rstn = 1'b1;
        step(1);
    endtask
    // Status strobes seen at exactly one sampling edge
    task automatic strobe(input logic ok, input logic fail, input logic back);
        config_ok = ok;
        config_fail = fail;
        edit_reenter = back;
        step(1);
        config_ok = 1'b0;
        config_fail = 1'b0;
        edit_reenter = 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************************************
    // Device and far side
    // ****************************************************************
    config_pin_reuse_mux u_config_pin_reuse_mux (
        .ref_clk(ref_clk), .rstn(rstn), .config_ok(config_ok), .config_fail(config_fail),
        .edit_reenter(edit_reenter), .manual_scan_cfg(manual_scan_cfg),
        .reuse_opt(reuse_opt), .mode_pins(mode_pins), .select_bonded(select_bonded),
        .small_family(small_family), .scan_port_select_n(scan_port_select_n),
        .reload_request_n(reload_request_n), .ready_in(ready_in), .pin_role(pin_role),
        .user_mode(user_mode), .done_out(done_out), .reload_start(reload_start)
    );
    cfg_host_model u_cfg_host_model (
        .ref_clk(ref_clk), .mode_pins(mode_pins), .scan_port_select_n(scan_port_select_n),
        .reload_request_n(reload_request_n), .ready_in(ready_in)
    );
    // Main sequence
    initial begin
        rstn = 1'b0;
        config_ok = 1'b0;
        config_fail = 1'b0;
        edit_reenter = 1'b0;
        manual_scan_cfg = 1'b0;
        reuse_opt = 7'h7F;
        select_bonded = 1'b1;
        small_family = 1'b0;
        reset_dut();
        `CHK("pin_role", 8'h00, pin_role)
        // Success refused while ready is held low
        u_cfg_host_model.set_pins(3'h0, 1'b1, 1'b0);
        strobe(1'b1, 1'b0, 1'b0);
        `CHK("done_out", 1'b0, done_out)
        `CHK("user_mode", 1'b0, user_mode)
        u_cfg_host_model.set_pins(3'h0, 1'b1, 1'b1);
        strobe(1'b1, 1'b0, 1'b0);
        `CHK("user_mode", 1'b1, user_mode)
        `CHK("done_out", 1'b1, done_out)
        `CHK("pin_role", 8'h7F, pin_role)
        // Live option and select changes in user mode
        u_cfg_host_model.set_pins(3'h0, 1'b0, 1'b1);
        step(1);
        `CHK("pin_role", 8'h3F, pin_role)
        reuse_opt = 7'h3F;
        step(1);
        `CHK("pin_role", 8'hBF, pin_role)
        reuse_opt = 7'h00;
        step(1);
        `CHK("pin_role", 8'h80, pin_role)
        // Each group follows its option bit; shared modes keep slave and master dedicated; ready low drops done
        reuse_opt = 7'h2A;
        step(1);
        `CHK("pin_role", 8'hAA, pin_role)
        reuse_opt = 7'h7F;
        u_cfg_host_model.set_pins(3'h5, 1'b1, 1'b1);
        step(1);
        `CHK("pin_role", 8'h67, pin_role)
        u_cfg_host_model.set_pins(3'h7, 1'b1, 1'b1);
        step(1);
        `CHK("pin_role", 8'h67, pin_role)
        u_cfg_host_model.set_pins(3'h0, 1'b1, 1'b0);
        step(1);
        `CHK("done_out", 1'b0, done_out)
        u_cfg_host_model.set_pins(3'h0, 1'b1, 1'b1);
        // Short reload ignored, minimum reload honoured
        u_cfg_host_model.pulse_reload(6);
        step(1);
        `CHK("reload_start", 1'b0, reload_start)
        `CHK("user_mode", 1'b1, user_mode)
        u_cfg_host_model.pulse_reload(7);
        step(1);
        `CHK("reload_start", 1'b1, reload_start)
        `CHK("user_mode", 1'b0, user_mode)
        `CHK("pin_role", 8'h00, pin_role)
        // Failure beats success and keeps every pin dedicated
        strobe(1'b1, 1'b1, 1'b0);
        strobe(1'b1, 1'b0, 1'b0);
        `CHK("user_mode", 1'b0, user_mode)
        `CHK("pin_role", 8'h00, pin_role)
        strobe(1'b0, 1'b0, 1'b1);
        // Combined scan release latched until edit mode
        small_family = 1'b1;
        u_cfg_host_model.set_pins(3'h1, 1'b1, 1'b1);
        strobe(1'b1, 1'b0, 1'b0);
        `CHK("pin_role", 8'hFF, pin_role)
        u_cfg_host_model.set_pins(3'h1, 1'b0, 1'b1);
        step(2);
        `CHK("pin_role", 8'hFF, pin_role)
        strobe(1'b0, 1'b0, 1'b1);
        `CHK("pin_role", 8'h00, pin_role)
        strobe(1'b1, 1'b0, 1'b0);
        `CHK("pin_role", 8'h3F, pin_role)
        // No select pin: scan freed only after manual scan configuration
        small_family = 1'b0;
        select_bonded = 1'b0;
        manual_scan_cfg = 1'b1;
        reset_dut();
        strobe(1'b1, 1'b0, 1'b0);
        `CHK("pin_role.scan", 1'b1, pin_role.scan)
        manual_scan_cfg = 1'b0;
        reset_dut();
        strobe(1'b1, 1'b0, 1'b0);
        `CHK("pin_role.scan", 1'b0, pin_role.scan)
        wrap_up();
    end
endmodule
